// ### design/hdt_duty_decoder.sv
// Purpose: Turn high time and period of the drive input into a signed code
// Assumes: Counts are taken over one full input period
// Notes: A zero period yields code -127
`timescale 1ns/1ps
module hdt_duty_decoder import hdt_pkg::*; #(
  parameter int CW = 16
) (
  input wire logic [CW-1:0] high_cycles_in,
  input wire logic [CW-1:0] period_cycles_in,
  output logic signed [7:0] drive_code_out
);

  int q;

  // Half duty maps to zero, each 1/254 of duty moves one step
  always_comb begin
    q = 0;
    if (period_cycles_in != '0) begin
      q = (DUTY_SPAN * int'(high_cycles_in)) / int'(period_cycles_in);
    end
    drive_code_out = hdt_sat8(q - CODE_MAX);
  end

endmodule

// ### design/hdt_haptic_thermal.sv
// Purpose: Haptic drive control and thermal supervisor
// Assumes: Drive input and short detector are asynchronous pins
// Notes: Temperature samples arrive from the sensor front end on request
// How it works
// - Nonzero load select enables haptics, zero disables
// - Load 10 rotating mass, 01 resonant carrier
// - Source bit picks input pin or register
// - Duty decoded to signed code each period
// - Rotating load squelches after 513 periods/ticks
// - Resonant envelope squelches after 513 carrier periods
// - Level is code/127 times 1.135 times gain/4
// - Drive level slew limited before the DAC
// - Register amplitude resampled at low oscillator rate, at pin rises when resonant
// - Resonant register mode uses pin for carrier
// - Short current grounds outputs, resumes when cleared
// - Periodic measurement when active, postponed during conversions
// - Continuous bit measures always, ignoring conversions
// - Warning and alarm flags from fixed levels
// - Alarm halts touch, proximity and haptics
// - Shutdown discards results, restarts cycling conversions
// - Haptics resume at once after shutdown
`timescale 1ns/1ps
module hdt_haptic_thermal import hdt_pkg::*; #(
  parameter int LOW_OSC_HZ = LOW_OSC_HZ_DEF,
  parameter int CW = 16
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic drive_pwm_in,
  input wire logic short_detect_in,
  input wire logic touch_active_in,
  input wire logic prox_active_in,
  input wire logic adc_busy_in,
  input wire logic [7:0] temp_value_in,
  input wire logic temp_valid_in,
  output logic temp_measure_out,
  output logic signed [7:0] dac_code_out,
  output logic motor_drive_en_out,
  output logic thermal_shutdown_out,
  output logic conversion_restart_out
);

  localparam int LOW_DIV = CLK_HZ / LOW_OSC_HZ;
  localparam int DW = $clog2(LOW_DIV + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and low oscillator tick

  logic pwm_s1, pwm_s2, pwm_d;
  logic short_s1, short_s2;
  logic [DW-1:0] div_cnt, next_div_cnt;
  logic low_tick, next_low_tick;
  logic pwm_rise;

  always_comb begin
    next_div_cnt = div_cnt + DW'(1);
    next_low_tick = 1'b0;
    if (div_cnt == DW'(LOW_DIV - 1)) begin
      next_div_cnt = '0;
      next_low_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pwm_s1 <= 1'b0;
      pwm_s2 <= 1'b0;
      pwm_d <= 1'b0;
      short_s1 <= 1'b0;
      short_s2 <= 1'b0;
      div_cnt <= '0;
      low_tick <= 1'b0;
    end else begin
      pwm_s1 <= drive_pwm_in;
      pwm_s2 <= pwm_s1;
      pwm_d <= pwm_s2;
      short_s1 <= short_detect_in;
      short_s2 <= short_s1;
      div_cnt <= next_div_cnt;
      low_tick <= next_low_tick;
    end
  end

  assign pwm_rise = pwm_s2 & ~pwm_d;

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  hdt_cfg_s cfg, next_cfg;
  hdt_stat_s stat;
  logic [7:0] rdata, next_rdata;

  always_comb begin
    next_cfg = cfg;
    next_rdata = 8'h00;
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_CTRL: begin
          next_cfg.load = reg_wdata_in[CTRL_LOAD_LSB +: 2];
          next_cfg.source = reg_wdata_in[CTRL_SRC_BIT];
          next_cfg.range = reg_wdata_in[CTRL_RANGE_BIT];
          next_cfg.cont = reg_wdata_in[CTRL_CONT_BIT];
        end
        ADDR_AMP: next_cfg.amp = reg_wdata_in;
        ADDR_SQUELCH: next_cfg.squelch = reg_wdata_in[6:0];
        ADDR_GAIN: next_cfg.gain = reg_wdata_in[3:0];
        ADDR_BW: next_cfg.bw = reg_wdata_in[3:0];
        default: next_cfg = cfg;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_CTRL: begin
          next_rdata[CTRL_LOAD_LSB +: 2] = cfg.load;
          next_rdata[CTRL_SRC_BIT] = cfg.source;
          next_rdata[CTRL_RANGE_BIT] = cfg.range;
          next_rdata[CTRL_CONT_BIT] = cfg.cont;
        end
        ADDR_AMP: next_rdata = cfg.amp;
        ADDR_SQUELCH: next_rdata = {1'b0, cfg.squelch};
        ADDR_GAIN: next_rdata = {4'h0, cfg.gain};
        ADDR_BW: next_rdata = {4'h0, cfg.bw};
        ADDR_STATUS: next_rdata = {4'h0, stat};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg.load <= CTRL_RST[CTRL_LOAD_LSB +: 2];
      cfg.source <= CTRL_RST[CTRL_SRC_BIT];
      cfg.range <= CTRL_RST[CTRL_RANGE_BIT];
      cfg.cont <= CTRL_RST[CTRL_CONT_BIT];
      cfg.amp <= AMP_RST;
      cfg.squelch <= SQUELCH_RST;
      cfg.gain <= GAIN_RST;
      cfg.bw <= BW_RST;
      rdata <= 8'h00;
    end else begin
      cfg <= next_cfg;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive input measurement and amplitude code

  logic [CW-1:0] high_cnt, next_high_cnt, per_cnt, next_per_cnt;
  logic signed [7:0] pwm_code, code, next_code;
  logic carrier, next_carrier;
  logic haptic_on, resonant, hold;

  hdt_duty_decoder #(
    .CW(CW)
  ) u_duty (
    .high_cycles_in(high_cnt),
    .period_cycles_in(per_cnt),
    .drive_code_out(pwm_code)
  );

  assign haptic_on = cfg.load != LOAD_OFF;
  assign resonant = cfg.load == LOAD_RESONANT;

  // Counters saturate so a stalled pin cannot wrap into a false duty
  always_comb begin
    next_high_cnt = high_cnt;
    next_per_cnt = per_cnt;
    next_carrier = carrier;
    next_code = code;
    if (pwm_rise) begin
      next_high_cnt = CW'(1);
      next_per_cnt = CW'(1);
      next_carrier = ~carrier;
    end else begin
      if (per_cnt != '1) begin
        next_per_cnt = per_cnt + CW'(1);
      end
      if (pwm_s2 && high_cnt != '1) begin
        next_high_cnt = high_cnt + CW'(1);
      end
    end
    if (!cfg.source) begin
      if (pwm_rise) begin
        next_code = pwm_code;
      end
    end else if (resonant) begin
      if (pwm_rise) begin
        next_code = cfg.amp;
      end
    end else if (low_tick) begin
      next_code = cfg.amp;
    end
    if (!haptic_on) begin
      next_carrier = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      high_cnt <= '0;
      per_cnt <= '0;
      carrier <= 1'b0;
      code <= 8'sh00;
    end else begin
      high_cnt <= next_high_cnt;
      per_cnt <= next_per_cnt;
      carrier <= next_carrier;
      code <= next_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Squelch, scaling and output stage

  logic [9:0] sq_cnt, next_sq_cnt;
  logic sq_event, in_band, squelched;
  logic [6:0] mag;
  logic signed [7:0] target, level;
  logic signed [7:0] dac, next_dac;
  logic drive_en, next_drive_en;

  function automatic logic signed [7:0] scale_code(input logic signed [7:0] c,
                                                   input logic [3:0] g);
    int p;
    p = (int'(c) * int'(g) * GAIN_NUM) / (GAIN_DEN * GAIN_UNIT);
    return hdt_sat8(p);
  endfunction

  assign mag = code[7] ? 7'(-code) : code[6:0];
  assign in_band = mag <= cfg.squelch;
  assign squelched = sq_cnt > SQUELCH_PERIODS;

  always_comb begin
    if (resonant) begin
      sq_event = pwm_rise & carrier;
    end else if (cfg.source) begin
      sq_event = low_tick;
    end else begin
      sq_event = pwm_rise;
    end
    next_sq_cnt = sq_cnt;
    if (!in_band || !haptic_on) begin
      next_sq_cnt = 10'h000;
    end else if (sq_event && !squelched) begin
      next_sq_cnt = sq_cnt + 10'h001;
    end
  end

  assign target = squelched ? 8'sh00 : scale_code(code, cfg.gain);

  hdt_slew_limiter u_slew (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .clear_in(hold),
    .step_tick_in(low_tick),
    .target_in(target),
    .step_in({1'b0, cfg.bw} + 5'h01),
    .level_out(level)
  );

  // Faults release straight back into normal drive, no host action
  assign hold = ~haptic_on | short_s2 | thermal_shutdown_out;

  always_comb begin
    next_drive_en = ~hold;
    next_dac = 8'sh00;
    if (!hold) begin
      next_dac = (resonant && !carrier) ? 8'(-level) : level;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sq_cnt <= 10'h000;
      dac <= 8'sh00;
      drive_en <= 1'b0;
    end else begin
      sq_cnt <= next_sq_cnt;
      dac <= next_dac;
      drive_en <= next_drive_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal supervisor

  hdt_therm_e th_state, next_th_state;
  logic [10:0] th_cnt, next_th_cnt;
  logic pending, next_pending;
  logic warn, next_warn, alarm, next_alarm;
  logic meas, next_meas, restart, next_restart;
  logic monitor_on;

  assign monitor_on = cfg.cont | haptic_on | touch_active_in | prox_active_in;

  always_comb begin
    next_th_state = th_state;
    next_th_cnt = th_cnt;
    next_pending = pending;
    next_warn = warn;
    next_alarm = alarm;
    next_meas = 1'b0;
    if (!monitor_on) begin
      next_th_state = TH_IDLE;
      next_th_cnt = 11'h000;
      next_pending = 1'b0;
      next_warn = 1'b0;
      next_alarm = 1'b0;
    end else begin
      if (low_tick) begin
        next_th_cnt = th_cnt + 11'h001;
        if (th_cnt == THERM_INTERVAL_TICKS - 11'h001) begin
          next_th_cnt = 11'h000;
          next_pending = 1'b1;
        end
      end
      case (th_state)
        TH_IDLE: begin
          // A busy converter only delays the sample when not continuous
          if (pending && (cfg.cont || !adc_busy_in)) begin
            next_meas = 1'b1;
            next_pending = 1'b0;
            next_th_state = TH_WAIT;
          end
        end
        TH_WAIT: begin
          if (temp_valid_in) begin
            next_warn = temp_value_in > WARN_TEMP;
            next_alarm = temp_value_in > ALARM_TEMP;
            next_th_state = TH_IDLE;
          end
        end
        default: next_th_state = TH_IDLE;
      endcase
    end
    next_restart = alarm & ~next_alarm;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      th_state <= TH_IDLE;
      th_cnt <= 11'h000;
      pending <= 1'b0;
      warn <= 1'b0;
      alarm <= 1'b0;
      meas <= 1'b0;
      restart <= 1'b0;
    end else begin
      th_state <= next_th_state;
      th_cnt <= next_th_cnt;
      pending <= next_pending;
      warn <= next_warn;
      alarm <= next_alarm;
      meas <= next_meas;
      restart <= next_restart;
    end
  end

  always_comb begin
    stat.short_flag = haptic_on & short_s2;
    stat.warn = warn;
    stat.alarm = alarm;
    stat.squelched = haptic_on & squelched;
  end

  assign reg_rdata_out = rdata;
  assign temp_measure_out = meas;
  assign dac_code_out = dac;
  assign motor_drive_en_out = drive_en;
  assign thermal_shutdown_out = alarm;
  assign conversion_restart_out = restart;

endmodule

// ### design/hdt_pkg.sv
// Purpose: Shared constants and types for the haptic drive and thermal supervisor
// Assumes: 8-bit register port, 10 MHz core clock
// Notes: Temperatures are whole degrees Celsius from the sensor front end
package hdt_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int LOW_OSC_HZ_DEF = 32_000;

  // Register map, word addresses on the plain register port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_AMP = 4'h1;
  localparam logic [3:0] ADDR_SQUELCH = 4'h2;
  localparam logic [3:0] ADDR_GAIN = 4'h3;
  localparam logic [3:0] ADDR_BW = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  // Control register fields
  localparam int CTRL_LOAD_LSB = 0;
  localparam int CTRL_SRC_BIT = 2;
  localparam int CTRL_RANGE_BIT = 3;
  localparam int CTRL_CONT_BIT = 4;

  // Status register fields
  localparam int STAT_SHORT_BIT = 0;
  localparam int STAT_WARN_BIT = 1;
  localparam int STAT_ALARM_BIT = 2;
  localparam int STAT_SQUELCH_BIT = 3;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] AMP_RST = 8'h00;
  localparam logic [6:0] SQUELCH_RST = 7'h02;
  localparam logic [3:0] GAIN_RST = 4'h4;
  localparam logic [3:0] BW_RST = 4'h3;

  // Load selection codes
  localparam logic [1:0] LOAD_OFF = 2'h0;
  localparam logic [1:0] LOAD_RESONANT = 2'h1;
  localparam logic [1:0] LOAD_ROTATING = 2'h2;

  // Timing counts
  localparam logic [9:0] SQUELCH_PERIODS = 10'h200;
  localparam logic [10:0] THERM_INTERVAL_TICKS = 11'h400;

  // Thermal levels in degrees Celsius
  localparam logic [7:0] WARN_TEMP = 8'h78;
  localparam logic [7:0] ALARM_TEMP = 8'h9B;

  // Amplitude arithmetic
  localparam int CODE_MAX = 127;
  localparam int DUTY_SPAN = 254;
  localparam int GAIN_NUM = 1135;
  localparam int GAIN_DEN = 1000;
  localparam int GAIN_UNIT = 4;

  typedef struct packed {
    logic [1:0] load;
    logic source;
    logic range;
    logic cont;
    logic signed [7:0] amp;
    logic [6:0] squelch;
    logic [3:0] gain;
    logic [3:0] bw;
  } hdt_cfg_s;

  typedef struct packed {
    logic squelched;
    logic alarm;
    logic warn;
    logic short_flag;
  } hdt_stat_s;

  typedef enum logic [1:0] {
    TH_IDLE = 2'b00,
    TH_WAIT = 2'b01
  } hdt_therm_e;

  function automatic logic signed [7:0] hdt_sat8(input int v);
    if (v > CODE_MAX) begin
      return 8'sh7F;
    end else if (v < -CODE_MAX) begin
      return -8'sh7F;
    end
    return 8'(v);
  endfunction

endpackage

// ### design/hdt_slew_limiter.sv
// Purpose: Rate limit the drive level ahead of the 8-bit DAC
// Assumes: step_tick_in is a one-cycle pulse
// Notes: clear_in drops the level to zero at once, faults must not ramp
`timescale 1ns/1ps
module hdt_slew_limiter import hdt_pkg::*; (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic clear_in,
  input wire logic step_tick_in,
  input wire logic signed [7:0] target_in,
  input wire logic [4:0] step_in,
  output logic signed [7:0] level_out
);

  logic signed [7:0] level;
  logic signed [7:0] next_level;
  logic signed [9:0] diff;
  logic signed [9:0] stp;
  logic signed [9:0] lvl_w;

  always_comb begin
    lvl_w = {{2{level[7]}}, level};
    stp = {5'h00, step_in};
    diff = {{2{target_in[7]}}, target_in} - lvl_w;
    next_level = level;
    if (clear_in) begin
      next_level = 8'sh00;
    end else if (step_tick_in) begin
      if (diff > stp) begin
        next_level = 8'(lvl_w + stp);
      end else if (diff < -stp) begin
        next_level = 8'(lvl_w - stp);
      end else begin
        next_level = target_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level <= 8'sh00;
    end else begin
      level <= next_level;
    end
  end

  assign level_out = level;

endmodule

// ### test/hdt_haptic_thermal_asserts.sv
// Purpose: Port level checker for the haptic drive and thermal supervisor
// Assumes: Control register shadowed from the register port
// Notes: One clock domain, default clocking and disable
`timescale 1ns/1ps
module hdt_haptic_thermal_asserts import hdt_pkg::*; #(
  parameter int LOW_OSC_HZ = LOW_OSC_HZ_DEF,
  parameter int CW = 16
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic drive_pwm_in,
  input wire logic short_detect_in,
  input wire logic touch_active_in,
  input wire logic prox_active_in,
  input wire logic adc_busy_in,
  input wire logic [7:0] temp_value_in,
  input wire logic temp_valid_in,
  input wire logic temp_measure_out,
  input wire logic signed [7:0] dac_code_out,
  input wire logic motor_drive_en_out,
  input wire logic thermal_shutdown_out,
  input wire logic conversion_restart_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [1:0] load_q;
  logic cont_q;
  logic wait_q;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      load_q <= LOAD_OFF;
      cont_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
        load_q <= reg_wdata_in[1:0];
        cont_q <= reg_wdata_in[CTRL_CONT_BIT];
      end
      wait_q <= temp_measure_out | (wait_q & ~temp_valid_in);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  property p_off;
    load_q == LOAD_OFF |=> !motor_drive_en_out && dac_code_out == 8'sh00;
  endproperty
  a_off: assert property (p_off) else $error("drive active with load off");
  property p_short;
    short_detect_in [*5] |-> !motor_drive_en_out && dac_code_out == 8'sh00;
  endproperty
  a_short: assert property (p_short) else $error("drive during short");
  property p_halt;
    thermal_shutdown_out |=> !motor_drive_en_out && dac_code_out == 8'sh00;
  endproperty
  a_halt: assert property (p_halt) else $error("drive during alarm");
  property p_alarm;
    wait_q && temp_valid_in |=> thermal_shutdown_out == ($past(temp_value_in) > ALARM_TEMP);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm level wrong");
  property p_restart;
    conversion_restart_out |-> $past(thermal_shutdown_out) && !thermal_shutdown_out;
  endproperty
  a_restart: assert property (p_restart) else $error("restart without alarm end");
  property p_postpone;
    temp_measure_out |-> $past(cont_q) || !$past(adc_busy_in);
  endproperty
  a_postpone: assert property (p_postpone) else $error("measure during conversion");
  property p_meas_pulse;
    temp_measure_out |=> !temp_measure_out ##1 !temp_measure_out;
  endproperty
  a_meas_pulse: assert property (p_meas_pulse) else $error("measure request too long");
endmodule

// ### test/hdt_haptic_thermal_bench.sv
// Purpose: Self-checking bench for the haptic drive and thermal supervisor
// Assumes: Fast low oscillator, five core cycles per tick
// Notes: Squelch and thermal intervals keep their real counts
`timescale 1ns/1ps
module hdt_haptic_thermal_bench import hdt_pkg::*; ;
  typedef struct packed {
    logic wr;
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } hdt_row_s;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic short_s = 1'b0;
  logic busy = 1'b0;
  logic touch = 1'b0;
  logic prox = 1'b0;
  int rs_n = 0;
  logic pwm_on = 1'b0;
  logic [7:0] high_c = 8'h32;
  logic [7:0] temp_c = 8'h19;
  logic [7:0] rdata, temp_v, v;
  logic pwm, temp_ok, meas, shut, restart, en, pos, neg;
  logic signed [7:0] dac;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  hdt_row_s rows [14];
  logic [7:0] hi [3] = '{8'h5A, 8'h0A, 8'h32};
  logic [7:0] ex [3] = '{8'h7F, 8'h81, 8'h00};
  logic [7:0] tv [3] = '{8'h79, 8'h9C, 8'h9B};
  logic [7:0] st [3] = '{8'h02, 8'h06, 8'h02};
  hdt_haptic_thermal #(.LOW_OSC_HZ(2_000_000), .CW(16)) u_hdt_haptic_thermal (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .drive_pwm_in(pwm),
    .short_detect_in(short_s), .touch_active_in(touch), .prox_active_in(prox),
    .adc_busy_in(busy), .temp_value_in(temp_v), .temp_valid_in(temp_ok),
    .temp_measure_out(meas), .dac_code_out(dac), .motor_drive_en_out(en),
    .thermal_shutdown_out(shut), .conversion_restart_out(restart));
  hdt_host_model u_hdt_host_model (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .pwm_on_in(pwm_on), .high_in(high_c),
    .period_in(8'h64), .temp_in(temp_c), .measure_in(meas), .pwm_out(pwm),
    .temp_value_out(temp_v), .temp_valid_out(temp_ok));
  ////////////////////////////////////////////////////////////////////////////
  always #50 clk_in = ~clk_in;
  // Restart pulses counted mid-cycle, where the output has settled
  always @(negedge clk_in) begin
    if (restart === 1'b1) begin
      rs_n++;
    end
  end
  // Ceiling well above the roughly 47k cycles the sequence needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_dac(input logic [7:0] e, input int lim);
    int n;
    n = 0;
    while (dac !== e && n < lim) begin
      step(1);
      n++;
    end
    check("dac", dac, e);
  endtask
  task automatic wait_meas(input int lim, input logic e);
    int n;
    n = 0;
    while (meas !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    check("measure", {7'h00, meas}, {7'h00, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{1'b0, 4'h0, 8'h00, 8'h00}, '{1'b0, 4'h1, 8'h00, 8'h00},
      '{1'b0, 4'h2, 8'h00, 8'h02}, '{1'b0, 4'h3, 8'h00, 8'h04},
      '{1'b0, 4'h4, 8'h00, 8'h03}, '{1'b0, 4'h5, 8'h00, 8'h00},
      '{1'b1, 4'h1, 8'h85, 8'h85}, '{1'b1, 4'h2, 8'hFF, 8'h7F},
      '{1'b1, 4'h3, 8'hFF, 8'h0F}, '{1'b1, 4'h4, 8'hF7, 8'h07},
      '{1'b1, 4'h0, 8'h10, 8'h10}, '{1'b1, 4'h5, 8'hFF, 8'h00},
      '{1'b1, 4'h6, 8'hFF, 8'h00}, '{1'b1, 4'hF, 8'h5A, 8'h00}};
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    step(1);
    check("dac_rst", dac, 8'h00);
    check("en_rst", {7'h00, en}, 8'h00);
    for (int i = 0; i < 14; i++) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d);
      end
      rd(rows[i].a, v);
      check("reg", v, rows[i].e);
    end
    @(posedge clk_in);
    busy <= 1'b1;
    wait_meas(6000, 1'b1);
    step(20);
    wr(ADDR_CTRL, 8'h00);
    wait_meas(6000, 1'b0);
    rd(ADDR_STATUS, v);
    check("status", v, 8'h00);
    @(posedge clk_in);
    busy <= 1'b0;
    touch <= 1'b1;
    wait_meas(6000, 1'b1);
    step(2);
    @(posedge clk_in);
    touch <= 1'b0;
    prox <= 1'b1;
    wait_meas(6000, 1'b1);
    step(2);
    @(posedge clk_in);
    busy <= 1'b1;
    prox <= 1'b0;
    wr(ADDR_SQUELCH, 8'h02);
    wr(ADDR_GAIN, 8'h08);
    wr(ADDR_BW, 8'h03);
    wr(ADDR_AMP, 8'h64);
    wr(ADDR_CTRL, 8'h0E);
    wait_meas(6000, 1'b0);
    wait_dac(8'h7F, 10);
    @(posedge clk_in);
    busy <= 1'b0;
    wait_meas(10, 1'b1);
    @(posedge clk_in);
    short_s <= 1'b1;
    step(8);
    check("en", {7'h00, en}, 8'h00);
    check("dac", dac, 8'h00);
    rd(ADDR_STATUS, v);
    check("status", v & 8'h07, 8'h01);
    @(posedge clk_in);
    short_s <= 1'b0;
    wait_dac(8'h7F, 500);
    wr(ADDR_AMP, 8'h9C);
    step(20);
    check("slew", {7'h00, dac[7]}, 8'h00);
    wait_dac(8'h81, 800);
    wr(ADDR_AMP, 8'h01);
    wait_dac(8'h02, 500);
    step(2200);
    check("dac", dac, 8'h02);
    step(400);
    check("dac", dac, 8'h00);
    rd(ADDR_STATUS, v);
    check("status", v, 8'h08);
    wr(ADDR_AMP, 8'h64);
    wait_dac(8'h7F, 500);
    wr(ADDR_CTRL, 8'h0A);
    @(posedge clk_in);
    pwm_on <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      high_c <= hi[i];
      wait_dac(ex[i], 3000);
    end
    wr(ADDR_CTRL, 8'h05);
    pos = 1'b0;
    neg = 1'b0;
    repeat (3000) begin
      step(1);
      pos |= (dac === 8'h7F);
      neg |= (dac === 8'h81);
    end
    check("carrier", {6'h00, pos, neg}, 8'h03);
    wr(ADDR_CTRL, 8'h0E);
    @(posedge clk_in);
    pwm_on <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      temp_c <= tv[i];
      wait_meas(6000, 1'b1);
      step(12);
      rd(ADDR_STATUS, v);
      check("status", v & 8'h07, st[i]);
      check("shutdown", {7'h00, shut}, {7'h00, st[i][2]});
      if (st[i][2]) begin
        check("dac", dac, 8'h00);
      end
    end
    check("restart", 8'(rs_n), 8'h01);
    wait_dac(8'h7F, 500);
    conclude();
  end
endmodule
bind hdt_haptic_thermal hdt_haptic_thermal_asserts #(.LOW_OSC_HZ(LOW_OSC_HZ), .CW(CW))
  u_hdt_haptic_thermal_asserts (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .drive_pwm_in(drive_pwm_in),
  .short_detect_in(short_detect_in), .touch_active_in(touch_active_in),
  .prox_active_in(prox_active_in), .adc_busy_in(adc_busy_in),
  .temp_value_in(temp_value_in), .temp_valid_in(temp_valid_in),
  .temp_measure_out(temp_measure_out), .dac_code_out(dac_code_out),
  .motor_drive_en_out(motor_drive_en_out), .thermal_shutdown_out(thermal_shutdown_out),
  .conversion_restart_out(conversion_restart_out));

// ### test/hdt_host_model.sv
// Purpose: Host side model, drive pin generator and temperature front end
// Assumes: Period and high time counted in core clock cycles
// Notes: Sensor answers each request after a fixed lag
`timescale 1ns/1ps
module hdt_host_model import hdt_pkg::*; (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic pwm_on_in,
  input wire logic [7:0] high_in,
  input wire logic [7:0] period_in,
  input wire logic [7:0] temp_in,
  input wire logic measure_in,
  output logic pwm_out,
  output logic [7:0] temp_value_out,
  output logic temp_valid_out
);
  logic [7:0] cnt;
  logic [3:0] lag;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= 8'h00;
      lag <= 4'h0;
      pwm_out <= 1'b0;
      temp_valid_out <= 1'b0;
      temp_value_out <= 8'h00;
    end else begin
      cnt <= (cnt + 8'h01 >= period_in) ? 8'h00 : cnt + 8'h01;
      // Pin grounded while off, high for the first high_in cycles of each period while on
      pwm_out <= pwm_on_in && (cnt < high_in);
      lag <= measure_in ? 4'h7 : ((lag != 4'h0) ? lag - 4'h1 : 4'h0);
      temp_valid_out <= (lag == 4'h1);
      // Scrambled outside the valid pulse so a stale value never looks fresh
      temp_value_out <= (lag == 4'h1) ? temp_in : ~temp_value_out;
    end
  end
endmodule
